// File: rtl/rsb_pkg.sv
/*
 * rsb_pkg: constants, register map and carrier types for the receiver
 * status and bring-up line block.
 * Assumes a 20 MHz system clock and a classic Wishbone slave with 32-bit
 * data and byte addresses.
 */
package rsb_pkg;

    // ****************************************************************
    // clock and timing
    // ****************************************************************
    localparam int unsigned CLK_MHZ        = 20;
    localparam int unsigned BOOT_TIME_US   = 100;
    localparam int unsigned BOOT_CYCLES    = BOOT_TIME_US * CLK_MHZ;
    localparam int unsigned BOOT_CNT_W     = 11;
    localparam logic [10:0] BOOT_LAST      = 11'(BOOT_CYCLES - 1);
    localparam int unsigned BLINK_TIME_MS  = 250;
    localparam int unsigned BLINK_CYCLES   = BLINK_TIME_MS * CLK_MHZ * 1000;
    localparam int unsigned BLINK_CNT_W    = 23;

    // ****************************************************************
    // register map (byte addresses)
    // ****************************************************************
    localparam int unsigned ADR_W          = 5;
    localparam logic [4:0]  OFS_CTRL       = 5'h00;
    localparam logic [4:0]  OFS_HEALTH     = 5'h04;
    localparam logic [4:0]  OFS_LOG_HDR    = 5'h08;
    localparam logic [4:0]  OFS_INT_STAT   = 5'h0C;
    localparam logic [4:0]  OFS_INT_MASK   = 5'h10;

    // ctrl field positions
    localparam int unsigned CTRL_FW_READY  = 0;
    localparam int unsigned CTRL_POS_VALID = 1;
    localparam int unsigned CTRL_ERROR     = 2;
    localparam int unsigned CTRL_ANT_EN    = 3;
    localparam int unsigned CTRL_W         = 4;

    // interrupt event positions
    localparam int unsigned EV_BOOT        = 0;
    localparam int unsigned EV_POS_RISE    = 1;
    localparam int unsigned EV_POS_FALL    = 2;
    localparam int unsigned EV_ANT_FAULT   = 3;
    localparam int unsigned EV_ERROR       = 4;
    localparam int unsigned EV_W           = 5;

    // reset values
    localparam logic [3:0]  CTRL_RESET     = 4'h0;
    localparam logic [4:0]  INT_RESET      = 5'h00;
    localparam logic [31:0] WORD_ZERO      = 32'h0000_0000;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef struct packed {
        logic ant_en;
        logic error;
        logic pos_valid;
        logic fw_ready;
    } rsb_ctrl_t;

    // receiver status word, bit 0 is error
    typedef struct packed {
        logic [25:0] rsvd;
        logic        int_pending;
        logic        boot_done;
        logic        pos_valid;
        logic        ant_en;
        logic        ant_fault;
        logic        error;
    } rsb_status_t;

    typedef enum logic [3:0] {
        RSB_HELD  = 4'b0001,
        RSB_BOOT  = 4'b0010,
        RSB_WAIT  = 4'b0100,
        RSB_READY = 4'b1000
    } rsb_state_t;

endpackage

// File: rtl/rsb_top.sv
/*
 * rsb_top: supervisory pins of the receiver. Host reset request in, boot
 * complete flag out, position valid, error, red/green status lines,
 * antenna supply enable out and antenna fault in, plus the 32-bit
 * receiver status word readable as health log and as log header copy.
 * Assumes internal firmware reaches the registers over classic Wishbone
 * on clk, and that reset_req_n and antenna_fault_input are asynchronous
 * pins.
 */
`timescale 1ns/10ps

// Function
// - boot flag only after boot and ready
// - antenna supply enable output switches antenna power
// - antenna enable high means power on
// - antenna fault input sampled by the device
// - position valid follows current solution validity
// - error output on unrecoverable condition
// - log header carries identical status word
// - red and green lines show state, errors
module rsb_top #(
    parameter int unsigned BLINK_CYCLES = rsb_pkg::BLINK_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        wb_cyc,
    input  wire logic        wb_stb,
    input  wire logic        wb_we,
    input  wire logic [4:0]  wb_adr,
    input  wire logic [3:0]  wb_sel,
    input  wire logic [31:0] wb_dat_w,
    output logic      [31:0] wb_dat_r,
    output logic             wb_ack,
    output logic             irq,
    input  wire logic        reset_req_n,
    input  wire logic        antenna_fault_input,
    output logic             boot_complete_flag,
    output logic             position_valid_out,
    output logic             error_out,
    output logic             antenna_supply_enable,
    output logic             status_red,
    output logic             status_green
);

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [1:0]              sync1;
    logic [1:0]              sync2;
    logic                    fault_d;
    logic                    req_active;
    logic                    fault_active;

    // two flops per pin; fault pin idles high, reset pin reads as held
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1 <= 2'b10;
            sync2 <= 2'b10;
        end else begin
            sync1 <= {antenna_fault_input, reset_req_n};
            sync2 <= sync1;
        end
    end

    assign req_active   = ~sync2[0];
    assign fault_active = ~sync2[1];

    // ****************************************************************
    // bus slave and registers
    // ****************************************************************
    rsb_pkg::rsb_ctrl_t      ctrl;
    rsb_pkg::rsb_status_t    status_word;
    rsb_pkg::rsb_state_t     state;
    logic [4:0]              int_stat;
    logic [4:0]              int_mask;
    logic [4:0]              events;
    logic [4:0]              int_clr;
    logic                    bus_req;
    logic                    wr_take;
    logic                    rd_take;
    logic [31:0]             next_dat;

    assign bus_req = wb_cyc & wb_stb & ~wb_ack;
    assign wr_take = wb_cyc & wb_stb & wb_ack & wb_we;
    assign rd_take = bus_req & ~wb_we;

    // read mux; unmapped addresses read zero
    always_comb begin
        next_dat = rsb_pkg::WORD_ZERO;
        unique case ({wb_adr[4:2], 2'b00})
            rsb_pkg::OFS_CTRL:     next_dat[3:0] = ctrl;
            rsb_pkg::OFS_HEALTH:   next_dat = status_word;
            rsb_pkg::OFS_LOG_HDR:  next_dat = status_word;
            rsb_pkg::OFS_INT_STAT: next_dat[4:0] = int_stat;
            rsb_pkg::OFS_INT_MASK: next_dat[4:0] = int_mask;
            default:               next_dat = rsb_pkg::WORD_ZERO;
        endcase
    end

    // ack one cycle after request, dropped the cycle after
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_ack   <= 1'b0;
            wb_dat_r <= rsb_pkg::WORD_ZERO;
        end else begin
            wb_ack <= bus_req;
            if (rd_take) begin
                wb_dat_r <= next_dat;
            end
        end
    end

    // control register; error is sticky until reset request
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl <= rsb_pkg::CTRL_RESET;
        end else if (req_active) begin
            ctrl <= rsb_pkg::CTRL_RESET;
        end else if (wr_take && wb_sel[0] &&
                     wb_adr[4:2] == rsb_pkg::OFS_CTRL[4:2]) begin
            ctrl.fw_ready  <= wb_dat_w[rsb_pkg::CTRL_FW_READY];
            ctrl.pos_valid <= wb_dat_w[rsb_pkg::CTRL_POS_VALID];
            ctrl.error     <= ctrl.error |
                              wb_dat_w[rsb_pkg::CTRL_ERROR];
            ctrl.ant_en    <= wb_dat_w[rsb_pkg::CTRL_ANT_EN];
        end
    end

    // interrupt mask
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            int_mask <= rsb_pkg::INT_RESET;
        end else if (wr_take && wb_sel[0] &&
                     wb_adr[4:2] == rsb_pkg::OFS_INT_MASK[4:2]) begin
            int_mask <= wb_dat_w[4:0];
        end
    end

    // sticky status, cleared by read; a new event wins over the clear
    assign int_clr = (rd_take &&
                      wb_adr[4:2] == rsb_pkg::OFS_INT_STAT[4:2]) ?
                     int_stat : rsb_pkg::INT_RESET;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            int_stat <= rsb_pkg::INT_RESET;
            irq      <= 1'b0;
        end else begin
            int_stat <= (int_stat & ~int_clr) | events;
            irq      <= |(((int_stat & ~int_clr) | events) & int_mask);
        end
    end

    // ****************************************************************
    // boot sequence
    // ****************************************************************
    logic [10:0]             boot_cnt;

    // held during reset request, counts boot time, waits for firmware
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= rsb_pkg::RSB_HELD;
        end else if (req_active) begin
            state <= rsb_pkg::RSB_HELD;
        end else begin
            unique case (state)
                rsb_pkg::RSB_HELD: begin
                    state <= rsb_pkg::RSB_BOOT;
                end
                rsb_pkg::RSB_BOOT: begin
                    if (boot_cnt == rsb_pkg::BOOT_LAST) begin
                        state <= rsb_pkg::RSB_WAIT;
                    end
                end
                rsb_pkg::RSB_WAIT: begin
                    if (ctrl.fw_ready) begin
                        state <= rsb_pkg::RSB_READY;
                    end
                end
                rsb_pkg::RSB_READY: begin
                    state <= rsb_pkg::RSB_READY;
                end
                default: begin
                    state <= rsb_pkg::RSB_HELD;
                end
            endcase
        end
    end

    // boot timer runs only in the boot state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            boot_cnt <= '0;
        end else if (state != rsb_pkg::RSB_BOOT || req_active) begin
            boot_cnt <= '0;
        end else begin
            boot_cnt <= boot_cnt + 11'h001;
        end
    end

    // ****************************************************************
    // blink divider
    // ****************************************************************
    logic [22:0]             blink_cnt;
    logic                    blink_phase;

    // toggles the blink phase once per blink period
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            blink_cnt   <= '0;
            blink_phase <= 1'b0;
        end else if (blink_cnt == 23'(BLINK_CYCLES - 1)) begin
            blink_cnt   <= '0;
            blink_phase <= ~blink_phase;
        end else begin
            blink_cnt <= blink_cnt + 23'h00_0001;
        end
    end

    // ****************************************************************
    // status word, events and pins
    // ****************************************************************
    logic                    ready_now;

    assign ready_now = (state == rsb_pkg::RSB_READY) & ~req_active;

    // status word assembled from live state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_word <= rsb_pkg::WORD_ZERO;
        end else begin
            status_word.rsvd        <= '0;
            status_word.int_pending <= |(int_stat & int_mask);
            status_word.boot_done   <= ready_now;
            status_word.pos_valid   <= ctrl.pos_valid & ready_now;
            status_word.ant_en      <= ctrl.ant_en & ~req_active;
            status_word.ant_fault   <= fault_active;
            status_word.error       <= ctrl.error;
        end
    end

    // edge events of the pins and outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fault_d <= 1'b0;
        end else begin
            fault_d <= fault_active;
        end
    end

    always_comb begin
        events = rsb_pkg::INT_RESET;
        events[rsb_pkg::EV_BOOT]      = ready_now & ~boot_complete_flag;
        events[rsb_pkg::EV_POS_RISE]  = ctrl.pos_valid & ready_now &
                                        ~position_valid_out;
        events[rsb_pkg::EV_POS_FALL]  = ~(ctrl.pos_valid & ready_now) &
                                        position_valid_out;
        events[rsb_pkg::EV_ANT_FAULT] = fault_active & ~fault_d;
        events[rsb_pkg::EV_ERROR]     = ctrl.error & ~error_out;
    end

    // output pins, all registered
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            boot_complete_flag    <= 1'b0;
            position_valid_out    <= 1'b0;
            error_out             <= 1'b0;
            antenna_supply_enable <= 1'b0;
            status_red            <= 1'b0;
            status_green          <= 1'b0;
        end else begin
            boot_complete_flag    <= ready_now;
            position_valid_out    <= ctrl.pos_valid & ready_now;
            error_out             <= ctrl.error;
            antenna_supply_enable <= ctrl.ant_en & ~req_active;
            // red steady on error, flashing on antenna fault
            status_red   <= ctrl.error | (fault_active & blink_phase);
            // green steady with fix, flashing while ready without fix
            status_green <= ready_now &
                            (ctrl.pos_valid | blink_phase);
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // firmware may clear its ready bit later; the state alone decides
    boot_flag_a: assert property (
        boot_complete_flag |-> $past(state) == rsb_pkg::RSB_READY &&
                               !$past(req_active))
        else $error("boot flag without finished boot");

    boot_time_a: assert property (
        $rose(state == rsb_pkg::RSB_WAIT) |->
            $past(boot_cnt) == rsb_pkg::BOOT_LAST)
        else $error("boot left before full boot time");

    reset_hold_a: assert property (
        req_active |=> !boot_complete_flag && !position_valid_out)
        else $error("boot flag high during reset request");

    ant_enable_a: assert property (
        (wr_take && wb_sel[0] && wb_adr[4:2] == rsb_pkg::OFS_CTRL[4:2]
         && !req_active) ##1 !req_active |=>
            antenna_supply_enable == $past(wb_dat_w[3], 2))
        else $error("antenna enable not following write");

    ant_fault_a: assert property (
        fault_active |=> status_word.ant_fault)
        else $error("antenna fault not seen");

    // a status read may clear the event bit, so only the onset is checked
    fault_event_a: assert property (
        $rose(fault_active) |=> int_stat[rsb_pkg::EV_ANT_FAULT])
        else $error("antenna fault event not latched");

    pos_valid_a: assert property (
        position_valid_out |-> $past(ctrl.pos_valid) &&
                               $past(state) == rsb_pkg::RSB_READY)
        else $error("position valid without solution");

    error_hold_a: assert property (
        error_out && !req_active && !$past(req_active) |=>
            error_out && status_red)
        else $error("error output dropped");

    log_copy_a: assert property (
        wb_ack && !wb_we && (wb_adr[4:2] == rsb_pkg::OFS_LOG_HDR[4:2] ||
                             wb_adr[4:2] == rsb_pkg::OFS_HEALTH[4:2]) |->
            wb_dat_r == $past(status_word))
        else $error("log header differs from status word");

    green_off_a: assert property (
        $past(state) != rsb_pkg::RSB_READY |-> !status_green)
        else $error("green lit before ready");

    cover_boot_c:  cover property ($rose(boot_complete_flag));
    cover_fix_c:   cover property ($rose(position_valid_out));
    cover_irq_c:   cover property ($rose(irq) && int_stat[3]);
    cover_rstrq_c: cover property (boot_complete_flag ##1 req_active);

endmodule

// File: testbench/rsb_host_model.sv
/*
 * rsb_host_model: host processor and antenna supply circuit facing the
 * receiver status and bring-up lines.
 * Assumes the bench commands reset and fault through hold_req and
 * fault_req; pins change only just after a rising edge of clk.
 */
`timescale 1ns/10ps

module rsb_host_model (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic hold_req,
    input  wire logic fault_req,
    input  wire logic boot_complete_flag,
    output logic      reset_req_n,
    output logic      antenna_fault_input,
    output logic      host_may_talk
);
    // ****************************************************************
    // host reset request and antenna fault line
    // ****************************************************************

    // reset held through host boot, reissued on request
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reset_req_n <= 1'b0;
        end else begin
            reset_req_n <= !hold_req;
        end
    end

    // fault pulls the line low, pull-up keeps it high otherwise
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            antenna_fault_input <= 1'b1;
        end else begin
            antenna_fault_input <= !fault_req;
        end
    end

    // host talks only once the boot flag is up
    assign host_may_talk = boot_complete_flag;
endmodule

// File: testbench/tb_top.sv
/*
 * tb_top: directed bench for rsb_top over classic Wishbone.
 * Assumes the host model drives the reset request and fault pins and
 * the blink period is shortened to 8 cycles.
 */
`timescale 1ns/10ps

module tb_top;
    logic        clk, rst, wb_cyc, wb_stb, wb_we, wb_ack, irq;
    logic [4:0]  wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_dat_w, wb_dat_r, rd;
    logic        reset_req_n, antenna_fault_input, host_may_talk;
    logic        hold_req, fault_req, boot_complete_flag;
    logic        position_valid_out, error_out, antenna_supply_enable;
    logic        status_red, status_green, red_prev;
    int          num_errors, tests_run, n;

    rsb_top #(.BLINK_CYCLES(8)) uut (
        .clk(clk), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
        .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
        .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
        .irq(irq), .reset_req_n(reset_req_n),
        .antenna_fault_input(antenna_fault_input),
        .boot_complete_flag(boot_complete_flag),
        .position_valid_out(position_valid_out), .error_out(error_out),
        .antenna_supply_enable(antenna_supply_enable),
        .status_red(status_red), .status_green(status_green));

    rsb_host_model host (
        .clk(clk), .rst(rst), .hold_req(hold_req), .fault_req(fault_req),
        .boot_complete_flag(boot_complete_flag), .reset_req_n(reset_req_n),
        .antenna_fault_input(antenna_fault_input),
        .host_may_talk(host_may_talk));

    // ****************************************************************
    // clock, tasks
    // ****************************************************************

    // 20 MHz clock
    always #25 clk = ~clk;

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one classic cycle, held until ack is sampled high
    task automatic wb_xfer(input logic we, input logic [4:0] a,
                           input logic [31:0] d, output logic [31:0] q);
        int k;
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_sel <= 4'hf;
        wb_adr <= a;
        wb_dat_w <= d;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (wb_ack !== 1'b1 && k < 20);
        q = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (k >= 20) begin
            num_errors++;
            print_verdict();
        end
    endtask

    task automatic wb_wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb_xfer(1'b1, a, d, q);
    endtask

    task automatic wb_rd(input logic [4:0] a, output logic [31:0] q);
        wb_xfer(1'b0, a, 32'h0000_0000, q);
    endtask

    // let outputs settle some edges after a change
    task automatic settle(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        clk = 0; rst = 1; wb_cyc = 0; wb_stb = 0; wb_we = 0;
        wb_adr = 5'h00; wb_sel = 4'hf; wb_dat_w = 32'h0000_0000;
        hold_req = 1; fault_req = 0; num_errors = 0; tests_run = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        wb_rd(rsb_pkg::OFS_CTRL, rd); check(rd, 32'h0000_0000);
        wb_rd(rsb_pkg::OFS_INT_MASK, rd); check(rd, 32'h0000_0000);
        wb_wr(5'h14, 32'h0000_ffff);
        wb_rd(5'h14, rd); check(rd, 32'h0000_0000);
        wb_wr(rsb_pkg::OFS_INT_MASK, 32'h0000_001f);
        hold_req <= 1'b0;
        settle(2100);
        check(boot_complete_flag, 1'b0);
        wb_wr(rsb_pkg::OFS_CTRL, 32'h0000_0001);
        n = 0;
        while (host_may_talk !== 1'b1 && n < 20) begin
            settle(1);
            n++;
        end
        if (n >= 20) begin
            num_errors++;
            print_verdict();
        end
        check(boot_complete_flag, 1'b1);
        settle(2);
        check(irq, 1'b1);
        wb_wr(rsb_pkg::OFS_CTRL, 32'h0000_000b);
        settle(4);
        check(position_valid_out, 1'b1);
        check(status_green, 1'b1);
        check(antenna_supply_enable, 1'b1);
        wb_rd(rsb_pkg::OFS_INT_STAT, rd); check(rd, 32'h0000_0003);
        wb_rd(rsb_pkg::OFS_INT_STAT, rd); check(rd, 32'h0000_0000);
        settle(3);
        check(irq, 1'b0);
        wb_rd(rsb_pkg::OFS_HEALTH, rd); check(rd, 32'h0000_001c);
        wb_rd(rsb_pkg::OFS_LOG_HDR, rd); check(rd, 32'h0000_001c);
        fault_req <= 1'b1;
        settle(6);
        check(irq, 1'b1);
        wb_rd(rsb_pkg::OFS_INT_STAT, rd); check(rd, 32'h0000_0008);
        settle(3);
        wb_rd(rsb_pkg::OFS_HEALTH, rd); check(rd, 32'h0000_001e);
        // red flashes during the fault: one blink period flips it
        settle(1);
        red_prev = status_red;
        settle(8);
        check(status_red, !red_prev);
        fault_req <= 1'b0;
        wb_wr(rsb_pkg::OFS_CTRL, 32'h0000_000f);
        settle(6);
        check(error_out, 1'b1);
        check(status_red, 1'b1);
        check(irq, 1'b1);
        wb_rd(rsb_pkg::OFS_CTRL, rd); check(rd, 32'h0000_000f);
        wb_rd(rsb_pkg::OFS_LOG_HDR, rd); check(rd, 32'h0000_003d);
        hold_req <= 1'b1;
        settle(5);
        check(boot_complete_flag, 1'b0);
        check(position_valid_out, 1'b0);
        check(antenna_supply_enable, 1'b0);
        check(error_out, 1'b0);
        hold_req <= 1'b0;
        settle(100);
        check(boot_complete_flag, 1'b0);
        // error rise and fix loss under the reset request stay latched
        wb_rd(rsb_pkg::OFS_INT_STAT, rd); check(rd, 32'h0000_0014);
        // boot restarts after release and ends once firmware is ready
        wb_wr(rsb_pkg::OFS_CTRL, 32'h0000_0001);
        n = 0;
        while (boot_complete_flag !== 1'b1 && n < 2100) begin
            settle(1);
            n++;
        end
        if (n >= 2100) begin
            num_errors++;
            print_verdict();
        end
        check(boot_complete_flag, 1'b1);
        check(antenna_supply_enable, 1'b0);
        print_verdict();
    end
endmodule
